// [rtl/acsp_params.svh]
`ifndef ACSP_PARAMS_SVH
`define ACSP_PARAMS_SVH

`define ACSP_OFS_MSTR_DIV 8'h0C
`define ACSP_OFS_PLL_REF 8'h0D
`define ACSP_OFS_DAC_SRC 8'h0E
`define ACSP_OFS_PLL_PIN 8'h12
`define ACSP_OFS_RESYNC 8'h13
`define ACSP_OFS_PLL_P 8'h14
`define ACSP_OFS_PLL_J 8'h15
`define ACSP_OFS_PLL_D_HI 8'h16
`define ACSP_OFS_PLL_D_LO 8'h17
`define ACSP_OFS_PLL_R 8'h18

`define ACSP_BIT_SCLK_DIV_RUN 1
`define ACSP_BIT_LRCK_DIV_RUN 0
`define ACSP_BIT_RESYNC 0

`define ACSP_REF_MCLK0 3'h0
`define ACSP_REF_MCLK1 3'h1
`define ACSP_REF_GPIN 3'h7
`define ACSP_PIN_ONE 3'h2
`define ACSP_PIN_ZERO 3'h3
`define ACSP_PIN_TWO 3'h5
`define ACSP_DAC_AUTO 3'h0
`define ACSP_DAC_PLL 3'h1
`define ACSP_DAC_MCLK 3'h3
`define ACSP_DAC_SCLK 3'h4

`define ACSP_P_BAD 4'hF
`define ACSP_J_BAD 5'h00
`define ACSP_D_MAX 14'h270F
`define ACSP_RST_BYTE 8'h00

`endif

// [rtl/acsp_pkg.sv]
package acsp_pkg;
  typedef enum logic [2:0] {
    ACSP_SRC_MUTE = 3'h0,
    ACSP_SRC_MCLK = 3'h1,
    ACSP_SRC_PLL = 3'h2,
    ACSP_SRC_SCLK = 3'h3,
    ACSP_SRC_OSC = 3'h4,
    ACSP_SRC_PIN0 = 3'h5,
    ACSP_SRC_PIN1 = 3'h6,
    ACSP_SRC_PIN2 = 3'h7
  } acsp_src_t;

  typedef enum logic [1:0] {
    ACSP_RUN = 2'h0,
    ACSP_HALT = 2'h1,
    ACSP_WAIT_FRAME = 2'h2
  } acsp_sync_t;

  typedef struct packed {
    logic [3:0] pre_div;
    logic [4:0] int_mult;
    logic [13:0] frac;
    logic [3:0] ratio;
    logic use_auto;
    logic bad_cfg;
  } acsp_pll_cfg_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acsp_bus_t;
endpackage

// [rtl/acsp_sync.sv]
`timescale 1ns/100ps
`include "acsp_params.svh"
module acsp_sync
  import acsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic frame_start,
  output logic halt
);
  // ************************************************************
  // Resync sequencer
  // ************************************************************
  typedef struct packed {
    acsp_sync_t st;
  } acsp_sync_st_t;
  acsp_sync_st_t s_r;
  acsp_sync_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      ACSP_RUN: begin
        if (req) begin
          s_nxt.st = ACSP_HALT;
        end
      end
      ACSP_HALT: begin
        if (!req) begin
          s_nxt.st = ACSP_WAIT_FRAME;
        end
      end
      ACSP_WAIT_FRAME: begin
        // A new request during the wait keeps the clocks stopped.
        if (req) begin
          s_nxt.st = ACSP_HALT;
        end else if (frame_start) begin
          s_nxt.st = ACSP_RUN;
        end
      end
      default: begin
        s_nxt.st = ACSP_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_r.st <= ACSP_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign halt = (s_r.st != ACSP_RUN);
endmodule

// [rtl/acsp_top.sv]
`timescale 1ns/100ps
`include "acsp_params.svh"
module acsp_top
  import acsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic auto_clk_mode,
  input wire logic frame_start,
  output logic sclk_div_run,
  output logic lrck_div_run,
  output acsp_src_t pll_ref_src,
  output acsp_src_t dac_clk_src,
  output logic dac_clk_halt,
  output logic charge_pump_clock_halt,
  output logic oversampling_clock_halt,
  output acsp_pll_cfg_t pll_cfg
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] mstr_div;
    logic [7:0] pll_ref;
    logic [7:0] dac_src;
    logic [7:0] pll_pin;
    logic [7:0] resync;
    logic [7:0] pll_p;
    logic [7:0] pll_j;
    logic [7:0] pll_d_hi;
    logic [7:0] pll_d_lo;
    logic [7:0] pll_r;
    logic [7:0] rdata;
    logic sclk_run;
    logic lrck_run;
    acsp_src_t ref_src;
    acsp_src_t dac_sel;
    logic halt;
    acsp_pll_cfg_t cfg;
  } acsp_state_t;

  acsp_state_t st_r;
  acsp_state_t st_nxt;
  logic sync_halt;

  acsp_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .req(st_r.resync[`ACSP_BIT_RESYNC]),
    .frame_start(frame_start),
    .halt(sync_halt)
  );

  // ************************************************************
  // Source decode
  // ************************************************************
  function automatic acsp_src_t pin_src(input logic [2:0] code);
    acsp_src_t r;
    r = ACSP_SRC_MUTE;
    if (code == `ACSP_PIN_ONE) begin
      r = ACSP_SRC_PIN1;
    end else if (code == `ACSP_PIN_ZERO) begin
      r = ACSP_SRC_PIN0;
    end else if (code == `ACSP_PIN_TWO) begin
      r = ACSP_SRC_PIN2;
    end
    return r;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [13:0] frac;
    frac = {st_r.pll_d_hi[5:0], st_r.pll_d_lo};
    st_nxt = st_r;
    if (reg_we) begin
      if (reg_addr == `ACSP_OFS_MSTR_DIV) begin
        st_nxt.mstr_div = {6'h00, reg_wdata[1:0]};
      end else if (reg_addr == `ACSP_OFS_PLL_REF) begin
        st_nxt.pll_ref = {1'b0, reg_wdata[6:4], 4'h0};
      end else if (reg_addr == `ACSP_OFS_DAC_SRC) begin
        st_nxt.dac_src = {1'b0, reg_wdata[6:4], 4'h0};
      end else if (reg_addr == `ACSP_OFS_PLL_PIN) begin
        st_nxt.pll_pin = {5'h00, reg_wdata[2:0]};
      end else if (reg_addr == `ACSP_OFS_RESYNC) begin
        st_nxt.resync = {7'h00, reg_wdata[0]};
      end else if (reg_addr == `ACSP_OFS_PLL_P) begin
        st_nxt.pll_p = {4'h0, reg_wdata[3:0]};
      end else if (reg_addr == `ACSP_OFS_PLL_J) begin
        st_nxt.pll_j = {3'h0, reg_wdata[4:0]};
      end else if (reg_addr == `ACSP_OFS_PLL_D_HI) begin
        st_nxt.pll_d_hi = {2'h0, reg_wdata[5:0]};
      end else if (reg_addr == `ACSP_OFS_PLL_D_LO) begin
        st_nxt.pll_d_lo = reg_wdata;
      end else if (reg_addr == `ACSP_OFS_PLL_R) begin
        st_nxt.pll_r = {4'h0, reg_wdata[3:0]};
      end
    end
    if (reg_addr == `ACSP_OFS_MSTR_DIV) begin
      st_nxt.rdata = st_r.mstr_div;
    end else if (reg_addr == `ACSP_OFS_PLL_REF) begin
      st_nxt.rdata = st_r.pll_ref;
    end else if (reg_addr == `ACSP_OFS_DAC_SRC) begin
      st_nxt.rdata = st_r.dac_src;
    end else if (reg_addr == `ACSP_OFS_PLL_PIN) begin
      st_nxt.rdata = st_r.pll_pin;
    end else if (reg_addr == `ACSP_OFS_RESYNC) begin
      st_nxt.rdata = st_r.resync;
    end else if (reg_addr == `ACSP_OFS_PLL_P) begin
      st_nxt.rdata = st_r.pll_p;
    end else if (reg_addr == `ACSP_OFS_PLL_J) begin
      st_nxt.rdata = st_r.pll_j;
    end else if (reg_addr == `ACSP_OFS_PLL_D_HI) begin
      st_nxt.rdata = st_r.pll_d_hi;
    end else if (reg_addr == `ACSP_OFS_PLL_D_LO) begin
      st_nxt.rdata = st_r.pll_d_lo;
    end else if (reg_addr == `ACSP_OFS_PLL_R) begin
      st_nxt.rdata = st_r.pll_r;
    end else begin
      st_nxt.rdata = 8'h00;
    end

    st_nxt.sclk_run = st_r.mstr_div[`ACSP_BIT_SCLK_DIV_RUN];
    st_nxt.lrck_run = st_r.mstr_div[`ACSP_BIT_LRCK_DIV_RUN];

    // Auto mode picks the master clock input; the PLL control decides the rest.
    if (auto_clk_mode) begin
      st_nxt.ref_src = ACSP_SRC_MCLK;
    end else if (st_r.pll_ref[6:4] == `ACSP_REF_MCLK0 ||
                 st_r.pll_ref[6:4] == `ACSP_REF_MCLK1) begin
      st_nxt.ref_src = ACSP_SRC_MCLK;
    end else if (st_r.pll_ref[6:4] == `ACSP_REF_GPIN) begin
      st_nxt.ref_src = pin_src(st_r.pll_pin[2:0]);
    end else begin
      st_nxt.ref_src = ACSP_SRC_MUTE;
    end

    if (st_r.dac_src[6:4] == `ACSP_DAC_AUTO) begin
      st_nxt.dac_sel = auto_clk_mode ? ACSP_SRC_OSC : ACSP_SRC_PLL;
    end else if (st_r.dac_src[6:4] == `ACSP_DAC_PLL) begin
      st_nxt.dac_sel = ACSP_SRC_PLL;
    end else if (st_r.dac_src[6:4] == `ACSP_DAC_MCLK) begin
      st_nxt.dac_sel = ACSP_SRC_MCLK;
    end else if (st_r.dac_src[6:4] == `ACSP_DAC_SCLK) begin
      st_nxt.dac_sel = ACSP_SRC_SCLK;
    end else begin
      st_nxt.dac_sel = ACSP_SRC_MUTE;
    end

    st_nxt.halt = sync_halt;

    st_nxt.cfg.pre_div = st_r.pll_p[3:0];
    st_nxt.cfg.int_mult = st_r.pll_j[4:0];
    st_nxt.cfg.frac = frac;
    st_nxt.cfg.ratio = st_r.pll_r[3:0];
    st_nxt.cfg.use_auto = auto_clk_mode;
    // Forbidden codes are flagged, outside auto mode only, rather than fixed so software sees its own mistake.
    st_nxt.cfg.bad_cfg = !auto_clk_mode &&
      (st_r.pll_p[3:0] == `ACSP_P_BAD || st_r.pll_j[4:0] == `ACSP_J_BAD ||
       frac > `ACSP_D_MAX);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign sclk_div_run = st_r.sclk_run;
  assign lrck_div_run = st_r.lrck_run;
  assign pll_ref_src = st_r.ref_src;
  assign dac_clk_src = st_r.dac_sel;
  assign dac_clk_halt = st_r.halt;
  assign charge_pump_clock_halt = st_r.halt;
  assign oversampling_clock_halt = st_r.halt;
  assign pll_cfg = st_r.cfg;
endmodule

// [tb/acsp_top_props.sv]
`timescale 1ns/100ps
module acsp_top_props
  import acsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic auto_clk_mode,
  input wire logic frame_start,
  input wire logic sclk_div_run,
  input wire logic lrck_div_run,
  input wire acsp_src_t pll_ref_src,
  input wire logic dac_clk_halt,
  input wire logic charge_pump_clock_halt,
  input wire logic oversampling_clock_halt,
  input wire acsp_pll_cfg_t pll_cfg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_sclk; reg_we && reg_addr == 8'h0C |-> ##2 sclk_div_run == $past(reg_wdata[1], 2);
  endproperty
  a_sclk: assert property (p_sclk) else $error("bit clock divider run wrong");
  property p_lrck; reg_we && reg_addr == 8'h0C |-> ##2 lrck_div_run == $past(reg_wdata[0], 2);
  endproperty
  a_lrck: assert property (p_lrck) else $error("frame clock divider run wrong");
  property p_halt; reg_we && reg_addr == 8'h13 && reg_wdata[0] |-> ##3 dac_clk_halt; endproperty
  a_halt: assert property (p_halt) else $error("halt not raised");
  property p_grp; dac_clk_halt == charge_pump_clock_halt &&
    dac_clk_halt == oversampling_clock_halt; endproperty
  a_grp: assert property (p_grp) else $error("halts disagree");
  property p_resume; $fell(dac_clk_halt) |-> $past(frame_start, 2); endproperty
  a_resume: assert property (p_resume) else $error("resume off frame");
  property p_aref; auto_clk_mode [*4] |-> pll_ref_src == ACSP_SRC_MCLK; endproperty
  a_aref: assert property (p_aref) else $error("auto reference wrong");
  property p_acfg; auto_clk_mode [*4] |-> pll_cfg.use_auto; endproperty
  a_acfg: assert property (p_acfg) else $error("auto config not used");
  property p_bad; (!auto_clk_mode && (pll_cfg.pre_div == 4'hF || pll_cfg.int_mult == 5'h00)) [*3]
    |-> pll_cfg.bad_cfg; endproperty
  a_bad: assert property (p_bad) else $error("forbidden code not flagged");
endmodule
bind acsp_top acsp_top_props i_acsp_top_props (.core_clk(core_clk), .rst_b(rst_b),
  .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .auto_clk_mode(auto_clk_mode),
  .frame_start(frame_start), .sclk_div_run(sclk_div_run), .lrck_div_run(lrck_div_run),
  .pll_ref_src(pll_ref_src), .dac_clk_halt(dac_clk_halt),
  .charge_pump_clock_halt(charge_pump_clock_halt),
  .oversampling_clock_halt(oversampling_clock_halt), .pll_cfg(pll_cfg));

// [tb/acsp_top_tb.sv]
`timescale 1ns/100ps
module acsp_top_tb;
  import acsp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_we = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic auto_clk_mode = 1'b0;
  logic frame_start = 1'b0;
  logic [7:0] reg_rdata;
  logic sclk_div_run;
  logic lrck_div_run;
  acsp_src_t pll_ref_src;
  acsp_src_t dac_clk_src;
  logic dac_clk_halt;
  logic charge_pump_clock_halt;
  logic oversampling_clock_halt;
  acsp_pll_cfg_t pll_cfg;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 32'hC620;
  int mdl [0:255];
  int exp_halt = 0;
  int i;
  int k;
  // The resync register sits last so random traffic never disturbs the halt model.
  int adrs [0:10] = '{8'h0C, 8'h0D, 8'h0E, 8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h20, 8'h13};
  always #2 core_clk = ~core_clk;
  acsp_top i_acsp_top (.core_clk(core_clk), .rst_b(rst_b), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .auto_clk_mode(auto_clk_mode), .frame_start(frame_start), .sclk_div_run(sclk_div_run),
    .lrck_div_run(lrck_div_run), .pll_ref_src(pll_ref_src), .dac_clk_src(dac_clk_src),
    .dac_clk_halt(dac_clk_halt), .charge_pump_clock_halt(charge_pump_clock_halt),
    .oversampling_clock_halt(oversampling_clock_halt), .pll_cfg(pll_cfg));
  // ****************
  // Model
  // ****************
  function automatic int fmask(int a);
    case (a)
      8'h0C: return 8'h03;
      8'h0D, 8'h0E: return 8'h70;
      8'h12: return 8'h07;
      8'h13: return 8'h01;
      8'h14, 8'h18: return 8'h0F;
      8'h15: return 8'h1F;
      8'h16: return 8'h3F;
      8'h17: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  function automatic int ref_exp();
    if (auto_clk_mode) return ACSP_SRC_MCLK;
    case (mdl[8'h0D] >> 4)
      0, 1: return ACSP_SRC_MCLK;
      7: return mdl[8'h12] == 2 ? ACSP_SRC_PIN1 : mdl[8'h12] == 3 ? ACSP_SRC_PIN0 :
        mdl[8'h12] == 5 ? ACSP_SRC_PIN2 : ACSP_SRC_MUTE;
      default: return ACSP_SRC_MUTE;
    endcase
  endfunction
  function automatic int dac_exp();
    case (mdl[8'h0E] >> 4)
      0: return auto_clk_mode ? ACSP_SRC_OSC : ACSP_SRC_PLL;
      1: return ACSP_SRC_PLL;
      3: return ACSP_SRC_MCLK;
      4: return ACSP_SRC_SCLK;
      default: return ACSP_SRC_MUTE;
    endcase
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(int a, int d);
    reg_we = 1'b1;
    reg_addr = a[7:0];
    reg_wdata = d[7:0];
    @(negedge core_clk);
    mdl[a] = d & fmask(a);
  endtask
  task automatic rd(int a);
    reg_we = 1'b0;
    reg_addr = a[7:0];
    @(negedge core_clk);
    chk("reg_rdata", mdl[a], reg_rdata);
  endtask
  task automatic chk_all();
    int fr;
    fr = mdl[8'h16] << 8 | mdl[8'h17];
    reg_we = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("sclk_div_run", mdl[8'h0C] >> 1 & 1, sclk_div_run);
    chk("lrck_div_run", mdl[8'h0C] & 1, lrck_div_run);
    chk("pll_ref_src", ref_exp(), pll_ref_src);
    chk("dac_clk_src", dac_exp(), dac_clk_src);
    chk("use_auto", auto_clk_mode, pll_cfg.use_auto);
    if (!auto_clk_mode) begin
      chk("pre_div", mdl[8'h14], pll_cfg.pre_div);
      chk("int_mult", mdl[8'h15], pll_cfg.int_mult);
      chk("frac", fr, pll_cfg.frac);
      chk("ratio", mdl[8'h18], pll_cfg.ratio);
      chk("bad_cfg", mdl[8'h14] == 15 || mdl[8'h15] == 0 || fr > 9999, pll_cfg.bad_cfg);
    end
    chk("dac_clk_halt", exp_halt, dac_clk_halt);
    chk("charge_pump_clock_halt", exp_halt, charge_pump_clock_halt);
    chk("oversampling_clock_halt", exp_halt, oversampling_clock_halt);
  endtask
  task automatic pulse_frame();
    frame_start = 1'b1;
    @(negedge core_clk);
    frame_start = 1'b0;
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    for (i = 0; i < 11; i++) rd(adrs[i]);
    $display("test reset_values done");
    for (k = 0; k < 8; k++) begin
      wr(8'h0D, 8'h70);
      wr(8'h12, k);
      wr(8'h0E, k << 4);
      chk_all();
      wr(8'h0D, k << 4 | 8'h8F);
      chk_all();
      rd(8'h0D);
    end
    $display("test codes done");
    for (k = 0; k < 60; k++) begin
      auto_clk_mode = 1'($random(seed));
      i = $unsigned($random(seed)) % 10;
      wr(adrs[i], $random(seed));
      wr(adrs[(i + 1) % 10], $random(seed));
      chk_all();
      rd(adrs[i]);
    end
    $display("test random done");
    auto_clk_mode = 1'b0;
    wr(8'h13, 8'h01);
    exp_halt = 1;
    chk_all();
    pulse_frame();
    chk_all();
    wr(8'h13, 8'h00);
    chk_all();
    pulse_frame();
    exp_halt = 0;
    chk_all();
    $display("test resync done");
    finish_test();
  end
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
